//--- src/fo_gpio_pkg.sv
package fo_gpio_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;  // Pin function, lock, test bit, pulls
  localparam logic [7:0] OFF_DEVICE_STATUS_REGISTER = 8'h04;  // Fault latch and watchdog flag
  localparam logic [7:0] OFF_WAKE_STAT = 8'h08;  // Wake event and level
  localparam logic [7:0] OFF_DIAG = 8'h0C;  // Overcurrent and open load
  localparam logic [7:0] OFF_PWM = 8'h10;  // Duty and frequency

  // Control register fields
  localparam int CTRL_FUNC_LSB = 0;  // pin_function_field [2:0]
  localparam int CTRL_LOCK_BIT = 3;  // config_lock_bit
  localparam int CTRL_TEST_BIT = 4;  // fail_pin_test_bit
  localparam int CTRL_OVR_BIT = 5;  // overvoltage_reset_enable
  localparam int CTRL_PULL_LSB = 6;  // pin_pull_select [1:0]
  localparam int CTRL_CFG34_BIT = 8;  // Second-fail watchdog configuration

  // Status fields
  localparam int STAT_FAULT_BIT = 0;  // fault_latched_flag
  localparam int STAT_WDF_BIT = 1;  // watchdog_fault_flag
  localparam int WAKE_EVENT_BIT = 0;  // pin_wake_event_flag
  localparam int WAKE_LEVEL_BIT = 1;  // wake_level_status
  localparam int DIAG_OC_BIT = 0;  // pin_overcurrent_flag
  localparam int DIAG_OL_BIT = 1;  // pin_open_load_flag

  // Pin function codes
  localparam logic [2:0] FUNC_FO_MAX = 3'h2;
  localparam logic [2:0] FUNC_CYCLIC = 3'h3;
  localparam logic [2:0] FUNC_OFF = 3'h4;
  localparam logic [2:0] FUNC_WAKE = 3'h5;
  localparam logic [2:0] FUNC_LOW_SIDE = 3'h6;
  localparam logic [2:0] FUNC_HIGH_SIDE = 3'h7;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] PWM_DUTY_RESET = 8'h00;

  // Timing
  localparam int CLK_MHZ = 50;
  localparam int WAKE_FILTER_US = 20;  // Longest filter time
  localparam int WAKE_BLANK_US = 40;  // Longest blanking time
  localparam int WAKE_FILTER_CYC = WAKE_FILTER_US * CLK_MHZ;
  localparam int WAKE_BLANK_CYC = WAKE_BLANK_US * CLK_MHZ;
  localparam int INT_PULSE_US = 100;
  localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;

  // Chip modes
  typedef enum logic [2:0] {
    MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE
  } chip_mode_e;

  // Failure inputs from the supervisor
  typedef struct packed {
    logic watchdog_fault_flag;  // Watchdog trigger failure, one-cycle pulse
    logic wd_ok;  // Successful watchdog trigger, pulse
    logic wd_off_stop;  // Watchdog disabled in stop mode, pulse
    logic thermal_shutdown_level_two;  // Level-two thermal shutdown, level
    logic short_gnd;  // Main supply short to ground, level
    logic overvolt;  // Main supply overvoltage, level
  } fail_in_s;

  // Switch diagnosis inputs
  typedef struct packed {
    logic oc;  // Overcurrent comparator
    logic ol;  // Open-load comparator
  } diag_in_s;

endpackage

//--- src/wake_qualifier.sv
`timescale 1ns/1ps
// Blanking then filtered level detection for the wake input
module wake_qualifier #(
  parameter int BLANK_CYC  = 2000,
  parameter int FILTER_CYC = 1000
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic enable,
  input  wire logic level_in,
  // Results
  output logic      filt_level,
  output logic      edge_pulse
);

  logic [15:0] blank_q;  // Blanking down counter
  logic [15:0] filt_q;  // Stability counter
  logic        filt_level_q;  // Last filtered value, low by default
  logic        edge_q;
  wire         blank_done = (blank_q == 16'h0000);
  wire         differs = (level_in != filt_level_q);

  // Blanking restarts each time the function is (re)selected
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      blank_q <= 16'(BLANK_CYC);
    end else if (!blank_done) begin
      blank_q <= blank_q - 16'h0001;
    end
  end

  // Reference is not cleared on disable: there is no learning cycle
  // [RULE21] last filtered reference
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_q       <= 16'h0000;
      filt_level_q <= 1'b0;
      edge_q       <= 1'b0;
    end else begin
      edge_q <= 1'b0;
      if (!enable || !blank_done || !differs) begin
        filt_q <= 16'h0000;
      end else if (filt_q == 16'(FILTER_CYC - 1)) begin
        filt_q       <= 16'h0000;
        filt_level_q <= level_in;
        edge_q       <= 1'b1;
      end else begin
        filt_q <= filt_q + 16'h0001;
      end
    end
  end

  assign filt_level = filt_level_q;
  assign edge_pulse = edge_q;

endmodule

//--- src/fail_output_gpio_control.sv
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Pin defaults to active-low fail output
// [RULE2] Watchdog failure fires; second in config 3/4
// [RULE3] Thermal, short, gated overvoltage fire too
// [RULE4] Fire sets latch and enters fail-safe, except watchdog fire in config 3/4
// [RULE5] Fired output stays low in all modes
// [RULE6] Release only normal, no failure, latch cleared
// [RULE7] Watchdog cause also needs successful trigger
// [RULE8] Watchdog flag cleared on sleep/failsafe/stop-off
// [RULE9] Test bit drives output; clear releases
// [RULE10] Test-only output dropped on restart entry
// [RULE11] Test bit always writable, drives fail function
// [RULE12] Codes 0-2 fail output, 4 off
// [RULE13] Lock bit blocks function field writes
// [RULE14] Code 5 wake input after blanking
// [RULE15] Wake events flagged, cleared at fail-safe
// [RULE16] Wake edge: pulse, flag, or wake up
// [RULE17] Level status tracks pin, read in normal
// [RULE18] Code 6 low-side PWM with overcurrent
// [RULE19] Code 7 high-side PWM with diagnosis
// [RULE20] Code 3 cyclic-sense switch via timer
// [RULE21] Wake reference low, last filtered value
// [RULE22] Fault or mode entry forces code 4
module fail_output_gpio_control #(
  parameter int BLANK_CYC  = fo_gpio_pkg::WAKE_BLANK_CYC,
  parameter int FILTER_CYC = fo_gpio_pkg::WAKE_FILTER_CYC,
  parameter int PULSE_CYC  = fo_gpio_pkg::INT_PULSE_CYC
) (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]              awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // AXI4-Lite read
  input  wire logic [7:0]              araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // Chip state and supervisor events
  input  wire fo_gpio_pkg::chip_mode_e chip_mode,
  input  wire fo_gpio_pkg::fail_in_s   fail_in,
  input  wire fo_gpio_pkg::diag_in_s   diag_in,
  input  wire logic                    pwm_on,
  input  wire logic                    timer_on,
  input  wire logic                    timer_start,
  // Pin: input, low-side drive, high-side drive
  input  wire logic                    pin_in,
  output logic                         pin_low_oe,
  output logic                         pin_high_oe,
  // Effects towards the chip
  output logic                         failsafe_req,
  output logic                         wake_req,
  output logic                         learn_start,
  output logic                         interrupt_pin_n
);
  // Register state
  logic [2:0]  func_q;  // pin_function_field
  logic        lock_q;  // config_lock_bit
  logic        test_q;  // fail_pin_test_bit
  logic        ovr_q;  // overvoltage_reset_enable
  logic [1:0]  pull_q;  // pin_pull_select
  logic        cfg34_q;  // Second watchdog failure needed
  logic [15:0] pwm_q;  // Duty and frequency words for the generator
  logic        fault_q;  // fault_latched_flag
  logic        wdf_q;  // watchdog_fault_flag
  logic        wd_cause_q;  // Latch caused by watchdog
  logic        fo_act_q;  // Fail output held by a failure
  logic        wd_count_q;  // First watchdog failure seen
  logic        wake_ev_q;  // pin_wake_event_flag
  logic        oc_q;  // pin_overcurrent_flag
  logic        ol_q;  // pin_open_load_flag
  fo_gpio_pkg::chip_mode_e mode_q;  // Chip mode one cycle ago, for entry events
  logic [15:0] int_cnt_q;  // Interrupt pulse counter
  logic        pin_s1_q, pin_s2_q;  // Pin synchroniser
  logic        aw_q, w_q;  // Write halves taken
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  // Decoded functions
  wire fo_func   = (func_q <= fo_gpio_pkg::FUNC_FO_MAX);
  wire wake_func = (func_q == fo_gpio_pkg::FUNC_WAKE);
  wire ls_func   = (func_q == fo_gpio_pkg::FUNC_LOW_SIDE);
  wire hs_func   = (func_q == fo_gpio_pkg::FUNC_HIGH_SIDE);
  wire cs_func   = (func_q == fo_gpio_pkg::FUNC_CYCLIC);
  wire sw_func   = ls_func | hs_func | cs_func;
  wire normal    = (chip_mode == fo_gpio_pkg::MODE_NORMAL);
  wire entering  = (chip_mode != mode_q);
  wire enter_rst = entering && (chip_mode == fo_gpio_pkg::MODE_RESTART);
  wire enter_fs  = entering && (chip_mode == fo_gpio_pkg::MODE_FAILSAFE);
  wire enter_slp = entering && (chip_mode == fo_gpio_pkg::MODE_SLEEP);

  // [RULE2] watchdog firing per configuration
  wire wd_fire   = fail_in.watchdog_fault_flag && (!cfg34_q || wd_count_q);
  // [RULE3] other failure sources
  wire hw_fire   = fail_in.thermal_shutdown_level_two | fail_in.short_gnd | (fail_in.overvolt & ovr_q);
  wire fire      = wd_fire | hw_fire;
  // [RULE6] any failure still present, overvoltage ungated
  wire fail_live = fail_in.thermal_shutdown_level_two | fail_in.short_gnd | fail_in.overvolt;

  // Switch on-time and diagnosis windows
  wire sw_on     = (ls_func | hs_func) ? pwm_on : (cs_func & timer_on);
  wire oc_hit    = sw_func & sw_on & diag_in.oc;
  wire ol_hit    = hs_func & pwm_on & diag_in.ol;
  // [RULE22] conditions that force the switch off
  wire sw_kill   = sw_func & (oc_hit | enter_rst | enter_fs);

  // Bus decode
  wire do_write  = aw_q && w_q && !bvalid;
  wire wr_ctrl   = do_write && (awaddr_q == fo_gpio_pkg::OFF_CTRL);
  wire wr_stat   = do_write && (awaddr_q == fo_gpio_pkg::OFF_DEVICE_STATUS_REGISTER);
  wire wr_wake   = do_write && (awaddr_q == fo_gpio_pkg::OFF_WAKE_STAT);
  wire wr_diag   = do_write && (awaddr_q == fo_gpio_pkg::OFF_DIAG);
  wire wr_pwm    = do_write && (awaddr_q == fo_gpio_pkg::OFF_PWM);
  wire wr_known  = wr_ctrl | wr_stat | wr_wake | wr_diag | wr_pwm;
  wire clr_fault = wr_stat && wstrb_q[0] && wdata_q[fo_gpio_pkg::STAT_FAULT_BIT];

  // Wake qualifier
  logic filt_level;
  logic wake_edge;
  wake_qualifier #(
    .BLANK_CYC  (BLANK_CYC),
    .FILTER_CYC (FILTER_CYC)
  ) u_wake (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .enable     (wake_func),
    .level_in   (pin_s2_q),
    .filt_level (filt_level),
    .edge_pulse (wake_edge)
  );

  // Pin synchroniser, first stage read only by the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      mode_q   <= fo_gpio_pkg::MODE_INIT;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      mode_q   <= chip_mode;
    end
  end

  // Write channel capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q  <= 1'b0;
      bvalid <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bresp    <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_q     <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= wr_known ? 2'h0 : 2'h2;  // Unmapped gives SLVERR
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_q   <= 1'b0;
        w_q    <= 1'b0;
      end
    end
  end
  assign awready = !aw_q;
  assign wready  = !w_q;

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // [RULE1] fail function after power-up
      func_q  <= fo_gpio_pkg::CTRL_RESET[2:0];
      lock_q  <= 1'b0;
      test_q  <= 1'b0;
      ovr_q   <= 1'b0;
      pull_q  <= 2'h0;
      cfg34_q <= 1'b0;
      pwm_q   <= {8'h00, fo_gpio_pkg::PWM_DUTY_RESET};
    end else begin
      if (wr_ctrl && wstrb_q[0]) begin
        // [RULE11] test bit writable in any function
        test_q <= wdata_q[fo_gpio_pkg::CTRL_TEST_BIT];
        lock_q <= wdata_q[fo_gpio_pkg::CTRL_LOCK_BIT];
        ovr_q  <= wdata_q[fo_gpio_pkg::CTRL_OVR_BIT];
        pull_q <= wdata_q[fo_gpio_pkg::CTRL_PULL_LSB +: 2];
        // [RULE13] locked field refuses writes
        if (!lock_q && normal) begin
          func_q <= wdata_q[fo_gpio_pkg::CTRL_FUNC_LSB +: 3];
        end
      end
      if (wr_ctrl && wstrb_q[1]) begin
        cfg34_q <= wdata_q[fo_gpio_pkg::CTRL_CFG34_BIT];
      end
      if (wr_pwm && wstrb_q[0]) begin
        pwm_q[7:0] <= wdata_q[7:0];
      end
      if (wr_pwm && wstrb_q[1]) begin
        pwm_q[15:8] <= wdata_q[15:8];
      end
      // [RULE22] hardware rewrite to off wins
      if (sw_kill) begin
        func_q <= fo_gpio_pkg::FUNC_OFF;
      end
      // [RULE10] test-only output dropped at restart
      if (enter_rst && !fo_act_q) begin
        test_q <= 1'b0;
      end
    end
  end

  // Failure latch and watchdog flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q    <= 1'b0;
      wdf_q      <= 1'b0;
      wd_cause_q <= 1'b0;
      fo_act_q   <= 1'b0;
      wd_count_q <= 1'b0;
    end else begin
      // [RULE8] watchdog flag clears on mode events
      if (enter_slp || fail_in.wd_off_stop || fail_in.wd_ok || (enter_fs && !wd_cause_q)) begin
        wdf_q <= 1'b0;
      end
      if (fail_in.wd_ok) begin
        wd_count_q <= 1'b0;
      end
      if (clr_fault) begin
        fault_q <= 1'b0;
      end
      // [RULE6] release in normal once all clear
      // [RULE7] watchdog cause needs flag cleared
      if (fo_act_q && normal && !fault_q && !fail_live && !(wd_cause_q && wdf_q)) begin
        fo_act_q   <= 1'b0;
        wd_cause_q <= 1'b0;
      end
      if (fail_in.watchdog_fault_flag) begin
        wdf_q      <= 1'b1;
        wd_count_q <= 1'b1;
      end
      // [RULE4] latch sets, set wins over clear
      // [RULE5] held in all modes
      if (fire) begin
        fault_q  <= 1'b1;
        fo_act_q <= 1'b1;
      end
      if (wd_fire) begin
        wd_cause_q <= 1'b1;
      end
    end
  end
  // [RULE4] fail-safe entry except watchdog fire in config 3/4
  assign failsafe_req = hw_fire | (wd_fire & !cfg34_q);

  // Wake, diagnosis flags and interrupt pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_ev_q <= 1'b0;
      oc_q      <= 1'b0;
      ol_q      <= 1'b0;
      int_cnt_q <= 16'h0000;
    end else begin
      if (int_cnt_q != 16'h0000) begin
        int_cnt_q <= int_cnt_q - 16'h0001;
      end
      if (wr_wake && wdata_q[fo_gpio_pkg::WAKE_EVENT_BIT]) begin
        wake_ev_q <= 1'b0;
      end
      // [RULE15] event flagged, wins over software clear
      if (wake_edge) begin
        wake_ev_q <= 1'b1;
      end
      // [RULE15] fail-safe entry clears
      if (enter_fs) begin
        wake_ev_q <= 1'b0;
      end
      // [RULE16] interrupt pulse in normal and stop
      if (wake_edge && (normal || chip_mode == fo_gpio_pkg::MODE_STOP) && int_cnt_q == 16'h0000) begin
        int_cnt_q <= 16'(PULSE_CYC);
      end
      if (wr_diag && wdata_q[fo_gpio_pkg::DIAG_OC_BIT]) begin
        oc_q <= 1'b0;
      end
      if (wr_diag && wdata_q[fo_gpio_pkg::DIAG_OL_BIT]) begin
        ol_q <= 1'b0;
      end
      // [RULE18] overcurrent flag during on-time
      if (oc_hit) begin
        oc_q <= 1'b1;
      end
      // [RULE19] open load flag, high-side only
      if (ol_hit) begin
        ol_q <= 1'b1;
      end
    end
  end
  assign interrupt_pin_n = (int_cnt_q == 16'h0000);
  // [RULE16] wake from sleep enables main supply
  assign wake_req = wake_edge && (chip_mode == fo_gpio_pkg::MODE_SLEEP);
  // [RULE20] learning cycle on timer start
  assign learn_start = cs_func & timer_start;

  // Pin drivers
  // [RULE9] test bit independent of failure latch
  // [RULE12] fail function codes, off code inert
  assign pin_low_oe  = (fo_func & (fo_act_q | test_q)) | (ls_func & pwm_on & !oc_q);
  // [RULE19] high-side driver, [RULE20] cyclic sense
  assign pin_high_oe = ((hs_func & pwm_on) | (cs_func & timer_on)) & !oc_q;

  // [RULE17] level status: pin level, not in cyclic sense
  wire level_bit = cs_func ? 1'b0 : pin_s2_q;
  wire [31:0] rd_mux =
    (araddr == fo_gpio_pkg::OFF_CTRL) ?
      {23'h0, cfg34_q, pull_q, ovr_q, test_q, lock_q, func_q} :
    (araddr == fo_gpio_pkg::OFF_DEVICE_STATUS_REGISTER) ? {30'h0, wdf_q, fault_q} :
    (araddr == fo_gpio_pkg::OFF_WAKE_STAT) ? {30'h0, level_bit, wake_ev_q} :
    (araddr == fo_gpio_pkg::OFF_DIAG) ? {30'h0, ol_q, oc_q} :
    (araddr == fo_gpio_pkg::OFF_PWM) ? {16'h0, pwm_q} : 32'h0000_0000;
  wire rd_known = (araddr == fo_gpio_pkg::OFF_CTRL) || (araddr == fo_gpio_pkg::OFF_DEVICE_STATUS_REGISTER) ||
    (araddr == fo_gpio_pkg::OFF_WAKE_STAT) || (araddr == fo_gpio_pkg::OFF_DIAG) ||
    (araddr == fo_gpio_pkg::OFF_PWM);

  // Read channel, one cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_known ? 2'h0 : 2'h2;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
  assign arready = !rvalid;

  // Latched failure keeps the fail output low
  a_fo_held_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (fo_act_q && fo_func) |-> pin_low_oe) else $error("fail output released while latched"); // [RULE5]
  a_fire_sets_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    hw_fire |=> (fault_q && fo_act_q)) else $error("failure did not latch"); // [RULE4]
  a_lock_blocks_func: assert property (@(posedge aclk) disable iff (!aresetn)
    (lock_q && !sw_kill) |=> $stable(func_q)) else $error("locked field changed"); // [RULE13]
  a_kill_forces_off: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_kill |=> (func_q == fo_gpio_pkg::FUNC_OFF)) else $error("switch not forced off"); // [RULE22]
  a_fs_clears_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    enter_fs |=> !wake_ev_q) else $error("wake flag survived fail-safe"); // [RULE15]
  a_int_pulse_low: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(interrupt_pin_n) |-> !interrupt_pin_n [*8]) else $error("interrupt pulse short"); // [RULE16]
  a_wd_release_blk: assert property (@(posedge aclk) disable iff (!aresetn)
    (wd_cause_q && wdf_q && fo_act_q) |=> fo_act_q) else $error("released before trigger"); // [RULE7]
  a_oc_disables_sw: assert property (@(posedge aclk) disable iff (!aresetn)
    oc_hit |=> !pin_high_oe && !(ls_func && pin_low_oe)) else $error("switch on after overcurrent"); // [RULE18]

endmodule

//--- testbench/pin_load_model.sv
`timescale 1ns/1ps
// Pin side: an external level, overridden by either on-chip driver
module pin_load_model (
  // Drivers from the block
  input  wire logic pin_low_oe,
  input  wire logic pin_high_oe,
  // Level that the outside world applies through its pull
  input  wire logic ext_level,
  // Resolved pin level
  output logic      pin_in
);
  // Low side wins over everything, as a strong sink does on the real wire
  assign pin_in = pin_low_oe ? 1'b0 : (pin_high_oe ? 1'b1 : ext_level);
endmodule

//--- testbench/fail_output_gpio_control_tb.sv
`timescale 1ns/1ps
module fail_output_gpio_control_tb;
  logic                    aclk = 0, aresetn = 0;      // Clock and reset
  logic [7:0]              awaddr = 0, araddr = 0;     // Bus addresses
  logic                    awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0]             wdata = 0, rd_q;            // Write data, last read
  logic [3:0]              wstrb = 0;                  // Byte lanes
  logic [1:0]              rr_q;                       // Last read response
  logic                    ext_level = 0, pwm_on = 0;  // Outside level, PWM phase
  fo_gpio_pkg::chip_mode_e chip_mode = fo_gpio_pkg::MODE_NORMAL;
  fo_gpio_pkg::fail_in_s   fail_in = '0;               // Supervisor events
  fo_gpio_pkg::diag_in_s   diag_in = '0;               // Switch comparators
  logic                    awready, wready, bvalid, arready, rvalid, pin_in;
  logic [1:0]              bresp, rresp;
  logic [31:0]             rdata;
  logic                    pin_low_oe, pin_high_oe, failsafe_req, wake_req, interrupt_pin_n;
  logic [15:0]             seed = 16'h37E8;            // LFSR state, starts at 14312
  int                      exp_ctrl, mismatches = 0, samples_checked = 0, n;

  always #10 aclk = ~aclk;

  fail_output_gpio_control #(.BLANK_CYC(20), .FILTER_CYC(10), .PULSE_CYC(20))
    fail_output_gpio_control_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .chip_mode(chip_mode), .fail_in(fail_in), .diag_in(diag_in),
    .pwm_on(pwm_on), .timer_on(1'b0), .timer_start(1'b0), .pin_in(pin_in),
    .pin_low_oe(pin_low_oe), .pin_high_oe(pin_high_oe), .failsafe_req(failsafe_req),
    .wake_req(wake_req), .learn_start(), .interrupt_pin_n(interrupt_pin_n));

  pin_load_model pin_load_model_i (.pin_low_oe(pin_low_oe), .pin_high_oe(pin_high_oe),
    .ext_level(ext_level), .pin_in(pin_in));

  // Verdict and end of run, also reached when a wait runs out
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One comparison, counted
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // A wait bound that ran out ends the run
  task automatic bound(input int k);
    if (k > 300) begin
      mismatches++;
      close_out();
    end
  endtask

  // Galois LFSR step for random payloads
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction

  // Write: both halves offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    for (n = 0; n <= 301; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
      if (bvalid === 1'b1) break;
      bound(n);
    end
    bready <= 0;
    @(posedge aclk);
    if (a == fo_gpio_pkg::OFF_CTRL) exp_ctrl = d;
  endtask

  // Read: address held until taken, rready held until the answer
  task automatic rd(input logic [7:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (n = 0; n <= 301; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 0;
      if (rvalid === 1'b1) break;
      bound(n);
    end
    rd_q = rdata;
    rr_q = rresp;
    rready <= 0;
    @(posedge aclk);
  endtask

  // Let register updates reach the combinational outputs
  task automatic settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask

  // One-cycle watchdog event pulses
  task automatic wd_pulse(input bit ok);
    @(posedge aclk);
    if (ok) fail_in.wd_ok <= 1; else fail_in.watchdog_fault_flag <= 1;
    @(posedge aclk);
    fail_in.wd_ok <= 0; fail_in.watchdog_fault_flag <= 0;
    settle();
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    settle();
    rd(fo_gpio_pkg::OFF_CTRL);
    chk(rd_q, fo_gpio_pkg::CTRL_RESET);  // reset config
    chk({pin_low_oe, interrupt_pin_n}, 2'b01);  // idle pins
    // Test bit drives the output, then restart entry drops it
    wr(fo_gpio_pkg::OFF_CTRL, 32'h10); settle();
    chk(pin_low_oe, 1'b1);  // test drive
    chk(pin_in, 1'b0);  // pin pulled low
    chip_mode <= fo_gpio_pkg::MODE_RESTART; settle();
    chip_mode <= fo_gpio_pkg::MODE_NORMAL; settle();
    chk(pin_low_oe, 1'b0);  // dropped at restart
    wr(fo_gpio_pkg::OFF_CTRL, 32'h14); settle();
    rd(fo_gpio_pkg::OFF_CTRL);
    chk(rd_q[4], 1'b1);  // bit writable when off
    chk(pin_low_oe, 1'b0);  // off ignores test bit
    wr(fo_gpio_pkg::OFF_CTRL, 32'h0);
    // Random duty words through the register path
    repeat (3) begin
      seed = lfsr(seed);
      wr(fo_gpio_pkg::OFF_PWM, {16'h0000, seed}); rd(fo_gpio_pkg::OFF_PWM);
      chk(rd_q[15:0], seed);  // duty word
    end
    // Thermal failure: latch, hold through stop, release only when gone
    fail_in.thermal_shutdown_level_two <= 1; settle();
    chk({pin_low_oe, failsafe_req}, 2'b11);  // fire
    rd(fo_gpio_pkg::OFF_DEVICE_STATUS_REGISTER);
    chk(rd_q[0], 1'b1);  // latch flag
    chip_mode <= fo_gpio_pkg::MODE_STOP; settle();
    chk(pin_low_oe, 1'b1);  // held in stop
    chip_mode <= fo_gpio_pkg::MODE_NORMAL;
    wr(fo_gpio_pkg::OFF_DEVICE_STATUS_REGISTER, 32'h1); settle();
    chk(pin_low_oe, 1'b1);  // cause still present
    fail_in.thermal_shutdown_level_two <= 0;
    wr(fo_gpio_pkg::OFF_DEVICE_STATUS_REGISTER, 32'h1); settle();
    chk(pin_low_oe, 1'b0);  // released
    // Second-fail configuration: first failure is deferred
    wr(fo_gpio_pkg::OFF_CTRL, 32'h100); wd_pulse(0);
    chk(pin_low_oe, 1'b0);  // first deferred
    wd_pulse(0);
    chk(pin_low_oe, 1'b1);  // second fires
    wr(fo_gpio_pkg::OFF_DEVICE_STATUS_REGISTER, 32'h1); settle();
    chk(pin_low_oe, 1'b1);  // trigger still needed
    wd_pulse(1);
    wr(fo_gpio_pkg::OFF_DEVICE_STATUS_REGISTER, 32'h1); settle();
    chk(pin_low_oe, 1'b0);  // released after trigger
    // Locked low-side switch, overcurrent forces code off
    wr(fo_gpio_pkg::OFF_CTRL, 32'hE); wr(fo_gpio_pkg::OFF_CTRL, 32'hF);
    rd(fo_gpio_pkg::OFF_CTRL);
    chk(rd_q[2:0], fo_gpio_pkg::FUNC_LOW_SIDE);  // write refused
    pwm_on <= 1; settle();
    chk(pin_low_oe, 1'b1);  // on-time drive
    diag_in.oc <= 1; settle();
    chk(pin_low_oe, 1'b0);  // shut off
    rd(fo_gpio_pkg::OFF_CTRL);
    chk(rd_q[2:0], fo_gpio_pkg::FUNC_OFF);  // code rewritten
    diag_in.oc <= 0; pwm_on <= 0;
    wr(fo_gpio_pkg::OFF_CTRL, 32'h4); wr(fo_gpio_pkg::OFF_CTRL, 32'h0);
    // Wake input: high level after blanking gives an interrupt pulse
    wr(fo_gpio_pkg::OFF_CTRL, 32'h5);
    ext_level <= 1;
    for (n = 0; interrupt_pin_n !== 1'b0; n++) begin
      @(posedge aclk); bound(n);
    end
    chk(interrupt_pin_n, 1'b0);  // pulse
    rd(fo_gpio_pkg::OFF_WAKE_STAT);
    chk(rd_q[1:0], 2'b11);  // flag and level
    // Fail-safe entry wipes the wake flag; level kept steady so no new edge
    chip_mode <= fo_gpio_pkg::MODE_FAILSAFE; settle();
    chip_mode <= fo_gpio_pkg::MODE_NORMAL; settle();
    rd(fo_gpio_pkg::OFF_WAKE_STAT);
    chk(rd_q[0], 1'b0);  // cleared at fail-safe
    // A falling level in sleep wakes the chip
    chip_mode <= fo_gpio_pkg::MODE_SLEEP;
    ext_level <= 0;
    for (n = 0; wake_req !== 1'b1; n++) begin
      @(posedge aclk); bound(n);
    end
    chk(wake_req, 1'b1);  // wake from sleep
    chip_mode <= fo_gpio_pkg::MODE_NORMAL;
    rd(8'h1C);
    chk(rr_q, 2'h2);  // unmapped place is refused
    close_out();
  end
endmodule
